/* File: hdl/psir_mgmt_regs.sv */
// Purpose: serial management slave for status and identifier registers
// Assumes: mdc and mdio_in synchronous to mclk, mdc well below mclk/4
// Notes: frames with or without preamble; only addresses 1, 2 answer reads
`timescale 1ns/1ps
`default_nettype none
module psir_mgmt_regs
    import psir_pkg::*;
#(
    // organisation identifier, bit n at position 24-n; value is arbitrary
    parameter logic [23:0] ORG_ID = 24'hA5C396
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // management serial link
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [4:0] phy_addr,
    // live indications from the transceiver
    input wire logic link_ok,
    input wire logic jabber,
    input wire logic speed_10,
    input wire logic remote_fault,
    input wire logic an_done
);
    localparam logic [15:0] ID_HIGH = ORG_ID[ORG_HI_POS:ORG_LO_POS]; // RULE12 RULE13

    logic rst_meta_ff, rst_sync_ff;
    logic mdc_ff, mdc_rise;
    psir_state_e state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [15:0] sh_ff, nxt_sh;
    logic [15:0] rdsh_ff, nxt_rdsh;
    logic [4:0] regad_ff, nxt_regad;
    logic drive_ff, nxt_drive;
    logic wr_ff, nxt_wr;
    logic mdio_out_ff, nxt_out;
    logic mdio_oe_ff, nxt_oe;
    logic rd_clr_ff, nxt_rd_clr;
    logic soft_rst_ff, nxt_soft_rst;
    logic [15:0] status_word;
    logic [11:0] hdr;
    logic [15:0] wr_word, rd_word;
    logic addr_hit, reg_known, hdr_read, hdr_write;

    // reset released through two flops, asserted at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // management clock edge found by sampling, mclk is the only clock
    assign mdc_rise = mdc & ~mdc_ff;

    // header decode: op, phy address, register address
    assign hdr = {sh_ff[10:0], mdio_in};
    assign addr_hit = hdr[9:5] == phy_addr;
    assign reg_known = (hdr[4:0] == REG_STATUS) || (hdr[4:0] == REG_ID_HIGH); // RULE1
    assign hdr_read = addr_hit && hdr[11:10] == OP_READ && reg_known;
    assign hdr_write = addr_hit && hdr[11:10] == OP_WRITE;
    assign rd_word = (hdr[4:0] == REG_STATUS) ? status_word : ID_HIGH; // RULE1
    assign wr_word = {sh_ff[14:0], mdio_in};

    // frame engine, one step per management clock rise
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_rdsh = rdsh_ff;
        nxt_regad = regad_ff;
        nxt_drive = drive_ff;
        nxt_wr = wr_ff;
        nxt_out = mdio_out_ff;
        nxt_oe = mdio_oe_ff;
        nxt_rd_clr = 1'b0;
        nxt_soft_rst = 1'b0;
        if (mdc_rise) begin
            nxt_sh = {sh_ff[14:0], mdio_in};
            unique case (state_ff)
                // idle ones need not be counted: no preamble is required
                PSIR_IDLE: begin
                    if (!mdio_in) begin
                        nxt_state = PSIR_START; // RULE4
                    end
                end
                PSIR_START: begin
                    nxt_state = mdio_in ? PSIR_HEADER : PSIR_IDLE;
                    nxt_cnt = 4'h0;
                end
                PSIR_HEADER: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff == HDR_LAST) begin
                        nxt_state = PSIR_TURN;
                        nxt_cnt = 4'h0;
                        nxt_regad = hdr[4:0];
                        nxt_drive = hdr_read;
                        nxt_wr = hdr_write;
                        nxt_rdsh = rd_word;
                        // snapshot taken now, so the clear cannot lose it
                        nxt_rd_clr = hdr_read && hdr[4:0] == REG_STATUS; // RULE6 RULE8 RULE9
                    end
                end
                PSIR_TURN: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff == 4'h0) begin
                        nxt_oe = drive_ff;
                        nxt_out = 1'b0;
                    end else begin
                        nxt_state = PSIR_DATA;
                        nxt_cnt = 4'h0;
                        nxt_out = rdsh_ff[15];
                        nxt_rdsh = {rdsh_ff[14:0], 1'b0};
                    end
                end
                PSIR_DATA: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    nxt_out = rdsh_ff[15];
                    nxt_rdsh = {rdsh_ff[14:0], 1'b0};
                    if (cnt_ff == DATA_LAST) begin
                        nxt_state = PSIR_IDLE;
                        nxt_oe = 1'b0;
                        nxt_out = 1'b0;
                        nxt_drive = 1'b0;
                        // writes to status and id are dropped; control reset is seen
                        nxt_soft_rst = wr_ff && regad_ff == REG_CONTROL
                            && wr_word[CTRL_SOFT_RST_BIT]; // RULE3 RULE14
                        nxt_wr = 1'b0;
                    end
                end
                default: begin
                    nxt_state = PSIR_IDLE;
                end
            endcase
        end
    end

    // engine and output flops
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            mdc_ff <= 1'b0;
            state_ff <= PSIR_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 16'h0000;
            rdsh_ff <= 16'h0000;
            regad_ff <= 5'h00;
            {drive_ff, wr_ff, mdio_out_ff, mdio_oe_ff} <= 4'h0;
            {rd_clr_ff, soft_rst_ff} <= 2'h0;
        end else begin
            mdc_ff <= mdc;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            rdsh_ff <= nxt_rdsh;
            regad_ff <= nxt_regad;
            {drive_ff, wr_ff, mdio_out_ff, mdio_oe_ff} <= {nxt_drive, nxt_wr, nxt_out, nxt_oe};
            {rd_clr_ff, soft_rst_ff} <= {nxt_rd_clr, nxt_soft_rst};
        end
    end

    assign mdio_out = mdio_out_ff;
    assign mdio_oe = mdio_oe_ff;

    // status flags and their latching
    psir_status_bank psir_status_bank_inst (
        .mclk(mclk),
        .rst_n(rst_sync_ff),
        .soft_rst(soft_rst_ff),
        .rd_clr(rd_clr_ff),
        .link_ok(link_ok),
        .jabber(jabber),
        .speed_10(speed_10),
        .remote_fault(remote_fault),
        .an_done(an_done),
        .status_word(status_word)
    );

    a_caps_fixed: assert property (@(posedge mclk) disable iff (!rst_sync_ff) // RULE2
        status_word[15:11] == 5'h0F)
        else $error("capability bits wrong");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_sync_ff) // RULE3
        status_word[10:7] == 4'h0 && $stable(status_word[10:7]))
        else $error("reserved status bits not zero");
    a_no_preamble_ok: assert property (@(posedge mclk) disable iff (!rst_sync_ff) // RULE4
        state_ff == PSIR_IDLE && mdc_rise && !mdio_in |=> state_ff == PSIR_START
            && status_word[6])
        else $error("frame start without preamble not taken");
    a_auto_neg_able: assert property (@(posedge mclk) disable iff (!rst_sync_ff) // RULE7
        status_word[3])
        else $error("negotiation ability bit clear");
    a_ext_capable: assert property (@(posedge mclk) disable iff (!rst_sync_ff) // RULE11
        status_word[0])
        else $error("extended capability bit clear");
    a_id_loaded: assert property (@(posedge mclk) disable iff (!rst_sync_ff) // RULE13
        mdc_rise && state_ff == PSIR_HEADER && cnt_ff == HDR_LAST && hdr_read
            && hdr[4:0] == REG_ID_HIGH |=> rdsh_ff == ID_HIGH && !rd_clr_ff)
        else $error("identifier word not loaded");
    a_clear_on_read: assert property (@(posedge mclk) disable iff (!rst_sync_ff) // RULE15
        rd_clr_ff |-> regad_ff == REG_STATUS && drive_ff && state_ff == PSIR_TURN)
        else $error("flags cleared outside a status read");
    a_turn_drive_zero: assert property (@(posedge mclk) disable iff (!rst_sync_ff) // RULE1
        $rose(mdio_oe_ff) |-> !mdio_out_ff && state_ff == PSIR_TURN && cnt_ff == 4'h1)
        else $error("turnaround not driven low");
    c_status_read: cover property (@(posedge mclk) rd_clr_ff ##[1:400] $fell(mdio_oe_ff));
    c_id_read: cover property (@(posedge mclk) mdio_oe_ff && regad_ff == REG_ID_HIGH);
    c_soft_reset: cover property (@(posedge mclk) soft_rst_ff);
endmodule // psir_mgmt_regs
`default_nettype wire

/* File: hdl/psir_pkg.sv */
// Purpose: constants for the management status and identifier registers
// Assumes: serial management frames sampled on the mclk domain
// Notes: rule summary below; all offsets and positions live here
// Contract
// RULE1: status at address 1, identifier at 2
// RULE2: bit15 reads 0, bits 14-11 read 1
// RULE3: bits 10-7 read zero, writes ignored
// RULE4: bit6 reads 1, accept preamble-less frames
// RULE5: bit5 shows negotiation done, reset 0
// RULE6: bit4 latches remote fault until read/reset
// RULE7: bit3 always reads 1
// RULE8: bit2 latch-low link, cleared until read
// RULE9: bit1 latches jabber until read/reset
// RULE10: jabber sets bit1 only at 10 Mbps
// RULE11: bit0 always reads 1
// RULE12: identifier registers form one device identifier; only the one at address 2 is built, address 3 does not answer
// RULE13: id register holds organisation bits 3-18
// RULE14: software reset restores latched flags' defaults
// RULE15: latched bits hold event until read/reset
// RULE16: after clearing read, flag shows live state
package psir_pkg;
    // management register addresses
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_ID_HIGH = 5'h02;
    localparam int CTRL_SOFT_RST_BIT = 15;
    // status field positions
    localparam int ST_AN_DONE = 5;
    localparam int ST_REMOTE_FAULT = 4;
    localparam int ST_LINK = 2;
    localparam int ST_JABBER = 1;
    // fixed capability pattern: bits 14-11, 6, 3, 0 set
    localparam logic [15:0] STATUS_FIXED = 16'h7849;
    localparam logic [15:0] STATUS_RESET = 16'h7849;
    // frame fields
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [3:0] HDR_LAST = 4'hB;
    localparam logic [3:0] DATA_LAST = 4'hF;
    // organisation id: bit n of the identifier sits at position 24-n
    localparam int ORG_HI_POS = 21;
    localparam int ORG_LO_POS = 6;
    typedef enum logic [2:0] {
        PSIR_IDLE = 3'b000,
        PSIR_START = 3'b001,
        PSIR_HEADER = 3'b010,
        PSIR_TURN = 3'b011,
        PSIR_DATA = 3'b100
    } psir_state_e;
endpackage

/* File: hdl/psir_status_bank.sv */
// Purpose: status word with latched fault, jabber and link flags
// Assumes: live indications synchronous to mclk
// Notes: status_word comes straight from flops
`timescale 1ns/1ps
`default_nettype none
module psir_status_bank
    import psir_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // controls from the frame engine
    input wire logic soft_rst,
    input wire logic rd_clr,
    // live indications
    input wire logic link_ok,
    input wire logic jabber,
    input wire logic speed_10,
    input wire logic remote_fault,
    input wire logic an_done,
    // register contents
    output logic [15:0] status_word
);
    logic link_ff, flt_ff, jab_ff, an_ff;
    logic nxt_link, nxt_flt, nxt_jab, jab_live;

    // jabber only counts at 10 Mbps
    assign jab_live = jabber & speed_10; // RULE10
    // latch-high: the set term wins over a clearing read
    assign nxt_flt = remote_fault | (flt_ff & ~rd_clr); // RULE6 RULE15 RULE16
    assign nxt_jab = jab_live | (jab_ff & ~rd_clr); // RULE9 RULE15 RULE16
    // latch-low: a read reloads the live level, a failure sticks
    assign nxt_link = rd_clr ? link_ok : (link_ff & link_ok); // RULE8 RULE15 RULE16

    // soft reset acts like chip reset on the flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {link_ff, flt_ff, jab_ff, an_ff} <= 4'h0;
        end else if (soft_rst) begin
            {link_ff, flt_ff, jab_ff, an_ff} <= 4'h0; // RULE14
        end else begin
            {link_ff, flt_ff, jab_ff, an_ff} <= {nxt_link, nxt_flt, nxt_jab, an_done}; // RULE5
        end
    end

    // fixed bits, reserved zeros and the four live fields
    always_comb begin
        status_word = STATUS_FIXED; // RULE2 RULE3 RULE4 RULE7 RULE11
        status_word[ST_AN_DONE] = an_ff;
        status_word[ST_REMOTE_FAULT] = flt_ff;
        status_word[ST_LINK] = link_ff;
        status_word[ST_JABBER] = jab_ff;
    end

    a_an_done_follow: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
        !soft_rst |=> status_word[ST_AN_DONE] == $past(an_done))
        else $error("negotiation done bit does not follow input");
    a_fault_held: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
        status_word[ST_REMOTE_FAULT] && !rd_clr && !soft_rst |=> status_word[ST_REMOTE_FAULT])
        else $error("remote fault flag dropped without read");
    a_link_drop_held: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
        !link_ok ##1 !rd_clr |-> !status_word[ST_LINK])
        else $error("link flag set again without read");
    a_jabber_fast_off: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
        !speed_10 && !status_word[ST_JABBER] |=> !status_word[ST_JABBER])
        else $error("jabber flag set at 100 Mbps");
    a_clear_shows_live: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
        rd_clr && !soft_rst |=> status_word[ST_REMOTE_FAULT] == $past(remote_fault)
            && status_word[ST_LINK] == $past(link_ok))
        else $error("flag after clearing read is not the live level");
    a_soft_rst_flags: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
        soft_rst |=> status_word == STATUS_RESET)
        else $error("software reset left a flag set");
    c_fault_cleared: cover property (@(posedge mclk) disable iff (!rst_n)
        status_word[ST_REMOTE_FAULT] ##1 rd_clr ##1 !status_word[ST_REMOTE_FAULT]);
endmodule // psir_status_bank
`default_nettype wire

/* File: sim/psir_mgmt_regs_bench.sv */
// Purpose: self-checking bench for the status and identifier registers
// Assumes: controller model drives frames with the line pulled up
// Notes: identifier value below is arbitrary
`timescale 1ns/1ps
`default_nettype none
module psir_mgmt_regs_bench
    import psir_pkg::*;
;
    localparam logic [23:0] TB_ORG = 24'h3C5A17; // arbitrary value
    logic mclk, rst_n, mdc, mdio_in, mdio_out, mdio_oe;
    logic link_ok, jabber, speed_10, remote_fault, an_done;
    logic [4:0] phy_addr;
    logic [15:0] id_exp;
    int errors, num_checks;
    // design and controller model
    psir_mgmt_regs #(.ORG_ID(TB_ORG)) psir_mgmt_regs_inst (.mclk(mclk), .rst_n(rst_n),
        .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .phy_addr(phy_addr), .link_ok(link_ok), .jabber(jabber), .speed_10(speed_10),
        .remote_fault(remote_fault), .an_done(an_done));
    psir_smi_master psir_smi_master_inst (.mclk(mclk), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe));
    // 100 ns clock
    always #50 mclk = ~mclk;
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // expected status: fixed pattern plus the four live/latched bits
    function automatic logic [15:0] st(input logic an, flt, lk, jb);
        return 16'h7849 | {10'h000, an, flt, 1'b0, lk, jb, 1'b0};
    endfunction
    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp, input string what);
        logic [15:0] v;
        psir_smi_master_inst.frame(1'b1, OP_READ, phy_addr, ra, 16'h0000, 3, v);
        check(what, v, exp);
        check("oe_after", {15'h0000, mdio_oe}, 16'h0000);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] v;
        psir_smi_master_inst.frame(1'b1, OP_WRITE, phy_addr, ra, d, 3, v);
    endtask
    task automatic t_defaults();
        rd_chk(REG_STATUS, st(0, 0, 0, 0), "status_rst");
        rd_chk(REG_ID_HIGH, id_exp, "id_high");
        rd_chk(REG_STATUS, st(0, 0, 1, 0), "link_live");
        $display("test defaults done");
    endtask
    task automatic t_latches();
        link_ok = 1'b0;
        remote_fault = 1'b1;
        jabber = 1'b1;
        cyc(3);
        link_ok = 1'b1;
        remote_fault = 1'b0;
        jabber = 1'b0;
        cyc(3);
        rd_chk(REG_STATUS, st(0, 1, 0, 1), "latched");
        rd_chk(REG_STATUS, st(0, 0, 1, 0), "cleared");
        remote_fault = 1'b1;
        rd_chk(REG_STATUS, st(0, 1, 1, 0), "flt_hold1");
        rd_chk(REG_STATUS, st(0, 1, 1, 0), "flt_hold2");
        remote_fault = 1'b0;
        rd_chk(REG_STATUS, st(0, 1, 1, 0), "flt_last");
        $display("test latches done");
    endtask
    task automatic t_speed_an();
        speed_10 = 1'b0;
        jabber = 1'b1;
        cyc(3);
        jabber = 1'b0;
        an_done = 1'b1;
        rd_chk(REG_STATUS, st(1, 0, 1, 0), "jab_100");
        an_done = 1'b0;
        speed_10 = 1'b1;
        rd_chk(REG_STATUS, st(0, 0, 1, 0), "an_off");
        $display("test speed done");
    endtask
    task automatic t_refused();
        logic [15:0] v;
        wr(REG_STATUS, 16'hFFFF);
        rd_chk(REG_STATUS, st(0, 0, 1, 0), "st_wr");
        wr(REG_ID_HIGH, 16'h0000);
        rd_chk(REG_ID_HIGH, id_exp, "id_wr");
        rd_chk(5'h03, 16'hFFFF, "unmapped");
        // the device keeps its own address while the controller aims elsewhere
        psir_smi_master_inst.frame(1'b1, OP_READ, 5'h06, REG_STATUS, 16'h0000, 3, v);
        check("other_addr", v, 16'hFFFF);
        check("oe_other", {15'h0000, mdio_oe}, 16'h0000);
        $display("test refused done");
    endtask
    task automatic t_soft_reset();
        logic [15:0] v;
        remote_fault = 1'b1;
        cyc(3);
        remote_fault = 1'b0;
        wr(REG_CONTROL, 16'h8000);
        rd_chk(REG_STATUS, st(0, 0, 0, 0), "soft_rst");
        // slow controller without preamble
        psir_smi_master_inst.frame(1'b0, OP_READ, phy_addr, REG_STATUS, 16'h0000, 5, v);
        check("no_pre", v, st(0, 0, 1, 0));
        $display("test soft reset done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        phy_addr = 5'h05;
        link_ok = 1'b1;
        jabber = 1'b0;
        speed_10 = 1'b1;
        remote_fault = 1'b0;
        an_done = 1'b0;
        errors = 0;
        num_checks = 0;
        // register bit 18-n holds identifier bit n, n from 3 to 18
        for (int n = 3; n <= 18; n++) id_exp[18-n] = TB_ORG[24-n];
        cyc(2);
        rst_n = 1'b1;
        cyc(3);
        t_defaults();
        t_latches();
        t_speed_an();
        t_refused();
        t_soft_reset();
        summarize();
    end
    // hang guard
    initial begin
        repeat (90000) @(posedge mclk);
        errors++;
        summarize();
    end
endmodule // psir_mgmt_regs_bench
`default_nettype wire

/* File: sim/psir_smi_master.sv */
// Purpose: station management controller model driving mdc and the data line
// Assumes: data line has a pull-up, so a released line reads 1
// Notes: mdc stands low between frames; phase length is per frame
`timescale 1ns/1ps
`default_nettype none
module psir_smi_master
    import psir_pkg::*;
(
    // clock
    input wire logic mclk,
    // management line
    output logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic drv_en;
    logic drv_val;
    // wire level: device while enabled, else ours, else pull-up
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b1;
    end
    // one bit: low phase with data set up, then high phase
    task automatic bit_cyc(input logic en, input logic val, input int hp);
        @(posedge mclk);
        #1;
        mdc = 1'b0;
        drv_en = en;
        drv_val = val;
        repeat (hp) @(posedge mclk);
        #1;
        mdc = 1'b1;
        repeat (hp) @(posedge mclk);
    endtask
    // whole frame; a read releases the line from the first turnaround bit
    task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd, input int hp,
                         output logic [15:0] rd);
        logic [31:0] bits;
        bits = {2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        if (pre) begin
            for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, hp);
        end
        for (int i = 0; i < 32; i++) begin
            // sample at the end of the previous high phase, before the rise that advances the device
            if (op == OP_READ && i >= 16) rd[31-i] = mdio_in;
            bit_cyc(!(op == OP_READ && i >= 14), bits[31-i], hp);
        end
        @(posedge mclk);
        #1;
        mdc = 1'b0;
        drv_en = 1'b0;
        repeat (4) @(posedge mclk);
        // hand back off the edge so callers never race the design's flops
        #1;
    endtask
endmodule // psir_smi_master
`default_nettype wire
